// >>> common/cmp_pwm_regs.svh
/*
  Register indexes, field positions, reset values and timing counts of the
  compare and PWM unit. Assumes one AXI4-Lite word per register index.
*/
`ifndef CMP_PWM_REGS_SVH
`define CMP_PWM_REGS_SVH
// ---------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ---------------------------------------------------------------
`define IDX_IRQ_FLAGS 8'h0C
`define IDX_T1_LOW 8'h0E
`define IDX_T1_HIGH 8'h0F
`define IDX_T1_CTL 8'h10
`define IDX_T2_COUNT 8'h11
`define IDX_T2_CTL 8'h12
`define IDX_MATCH_LOW 8'h15
`define IDX_MATCH_HIGH 8'h16
`define IDX_UNIT_CTL 8'h17
`define IDX_IRQ_EN 8'h8C
`define IDX_T2_PERIOD 8'h92
// ---------------------------------------------------------------
// Reset values and implemented-bit masks
// ---------------------------------------------------------------
`define RST_T2_PERIOD 8'hFF
`define RST_ZERO 8'h00
`define IRQ_MASK 8'h07
`define T1_CTL_MASK 8'h3F
`define T2_CTL_MASK 8'h7F
`define UNIT_CTL_MASK 8'h3F
// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define T1_IRQ_BIT 0
`define T2_IRQ_BIT 1
`define UNIT_IRQ_BIT 2
`define T1_RUN_BIT 0
`define T2_RUN_BIT 2
// ---------------------------------------------------------------
// Mode codes
// ---------------------------------------------------------------
`define MODE_OFF 4'h0
`define MODE_SET 4'h8
`define MODE_CLR 4'h9
`define MODE_SWI 4'hA
`define MODE_SPECIAL 4'hB
// ---------------------------------------------------------------
// Timing: oscillator period and clocks per instruction cycle
// ---------------------------------------------------------------
`define OSC_PERIOD_NS 4
`define CLK_PER_NS 4
`define QCLK_PER_INSTR (4 * `OSC_PERIOD_NS / `CLK_PER_NS)
`endif

// >>> common/cmp_pwm_pkg.sv
/*
  Types of the compare and PWM unit: the whole state as one packed struct.
  Assumes the register header is included by the design file.
*/
package cmp_pwm_pkg;
  typedef struct packed {
    logic aw_held;
    logic w_held;
    logic [7:0] widx;
    logic wok;
    logic [7:0] wdata;
    logic wstb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [7:0] rdata;
    logic [7:0] flags;
    logic [7:0] enables;
    logic [15:0] t1_cnt;
    logic [7:0] t1_ctl;
    logic [2:0] t1_pre;
    logic [7:0] t2_cnt;
    logic [7:0] t2_ctl;
    logic [3:0] t2_pre;
    logic [3:0] t2_post;
    logic [7:0] period;
    logic [7:0] match_lo;
    logic [7:0] match_hi;
    logic [7:0] unit_ctl;
    logic [1:0] duty_lat;
    logic [1:0] qclk;
    logic out_latch;
    logic match_prev;
    logic adc_pulse;
    logic irq_q;
  } state_t;
endpackage

// >>> core/compare_and_pwm_unit.sv
/*
  Compare and PWM unit with its two timers, an AXI4-Lite register slave
  and a level interrupt. Assumes the pin direction and the port data
  latch sit outside, and that all inputs share clk_sys.
*/
`timescale 1ns/100ps
`include "cmp_pwm_regs.svh"

module compare_and_pwm_unit
  import cmp_pwm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic adc_enabled,
  output logic adc_start,
  output logic unit_output_pin,
  output logic irq
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  localparam state_t ST_RESET = '{period: `RST_T2_PERIOD, default: '0};

  function automatic logic [8:0] decode(input logic [11:0] a);
    logic [7:0] i;
    logic hit;
    i = a[9:2];
    hit = (a[1:0] == 2'h0) && (a[11:10] == 2'h0);
    case (i)
      `IDX_IRQ_FLAGS, `IDX_T1_LOW, `IDX_T1_HIGH, `IDX_T1_CTL,
      `IDX_T2_COUNT, `IDX_T2_CTL, `IDX_MATCH_LOW, `IDX_MATCH_HIGH,
      `IDX_UNIT_CTL, `IDX_IRQ_EN, `IDX_T2_PERIOD: decode = {hit, i};
      default: decode = {1'b0, i};
    endcase
  endfunction

  function automatic logic [7:0] reg_read(input state_t s, input logic [7:0] i);
    case (i)
      `IDX_IRQ_FLAGS: reg_read = s.flags;
      `IDX_T1_LOW: reg_read = s.t1_cnt[7:0];
      `IDX_T1_HIGH: reg_read = s.t1_cnt[15:8];
      `IDX_T1_CTL: reg_read = s.t1_ctl;
      `IDX_T2_COUNT: reg_read = s.t2_cnt;
      `IDX_T2_CTL: reg_read = s.t2_ctl;
      `IDX_MATCH_LOW: reg_read = s.match_lo;
      `IDX_MATCH_HIGH: reg_read = s.match_hi;
      `IDX_UNIT_CTL: reg_read = s.unit_ctl;
      `IDX_IRQ_EN: reg_read = s.enables;
      `IDX_T2_PERIOD: reg_read = s.period;
      default: reg_read = `RST_ZERO;
    endcase
  endfunction

  // Position in the PWM period: Timer2 over two sub-step bits
  function automatic logic [9:0] pwm_pos(input state_t s);
    logic [1:0] sub;
    case (s.t2_ctl[1:0])
      2'b00: sub = s.qclk;
      2'b01: sub = s.t2_pre[1:0];
      default: sub = s.t2_pre[3:2];
    endcase
    pwm_pos = {s.t2_cnt, sub};
  endfunction

  state_t st;
  state_t next_st;
  logic [3:0] mode;
  logic pwm_mode;
  logic cmp_mode;
  logic instr_tick;
  logic t1_run;
  logic t2_run;
  logic [2:0] t1_mask;
  logic t1_tick;
  logic t2_due;
  logic period_end;
  logic match_eq;
  logic cmp_hit;
  logic duty_hit;
  logic wr_fire;
  logic [8:0] aw_dec;
  logic [8:0] ar_dec;

  assign mode = st.unit_ctl[3:0];
  assign pwm_mode = (mode[3:2] == 2'b11);
  assign cmp_mode = (mode[3:2] == 2'b10);
  assign instr_tick = (st.qclk == 2'(`QCLK_PER_INSTR - 1));
  assign t1_run = st.t1_ctl[`T1_RUN_BIT];
  assign t2_run = st.t2_ctl[`T2_RUN_BIT];
  assign t1_mask = 3'((4'h1 << st.t1_ctl[5:4]) - 4'h1);
  assign t1_tick = instr_tick && t1_run && ((st.t1_pre | ~t1_mask) == 3'h7);
  // Divide by 1, 4 or 16 ahead of Timer2
  assign t2_due = instr_tick && t2_run &&
                  ((st.t2_ctl[1:0] == 2'b00) ||
                   (st.t2_ctl[1:0] == 2'b01 && st.t2_pre[1:0] == 2'h3) ||
                   (st.t2_ctl[1] && st.t2_pre == 4'hF));
  assign period_end = t2_due && (st.t2_cnt == st.period);
  assign match_eq = (st.t1_cnt == {st.match_hi, st.match_lo});
  assign cmp_hit = cmp_mode && match_eq && !st.match_prev;
  assign wr_fire = st.aw_held && st.w_held;
  assign aw_dec = decode(awaddr);
  assign ar_dec = decode(araddr);

  // ---------------------------------------------------------------
  // Bus handshakes and outputs
  // ---------------------------------------------------------------
  assign awready = !st.aw_held && !st.bvalid;
  assign wready = !st.w_held && !st.bvalid;
  assign arready = !st.rvalid;
  assign bvalid = st.bvalid;
  assign bresp = st.bresp;
  assign rvalid = st.rvalid;
  assign rresp = st.rresp;
  assign rdata = {24'h000000, st.rdata};
  assign adc_start = st.adc_pulse;
  assign unit_output_pin = st.out_latch;
  assign irq = st.irq_q;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [7:0] set_f;
    logic [7:0] clr_f;
    logic [16:0] t1_sum;
    set_f = 8'h00;
    clr_f = 8'h00;
    t1_sum = 17'h00000;
    next_st = st;
    next_st.adc_pulse = 1'b0;

    // Write channel capture and response
    if (awvalid && awready) begin
      next_st.aw_held = 1'b1;
      next_st.widx = aw_dec[7:0];
      next_st.wok = aw_dec[8];
    end
    if (wvalid && wready) begin
      next_st.w_held = 1'b1;
      next_st.wdata = wdata[7:0];
      next_st.wstb = wstrb[0];
    end
    if (st.bvalid && bready) begin
      next_st.bvalid = 1'b0;
    end
    if (wr_fire) begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = st.wok ? 2'b00 : 2'b10;
    end

    // Read channel
    if (st.rvalid && rready) begin
      next_st.rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = ar_dec[8] ? 2'b00 : 2'b10;
      next_st.rdata = ar_dec[8] ? reg_read(st, ar_dec[7:0]) : 8'h00;
    end

    // Quarter clock and Timer1
    next_st.qclk = st.qclk + 2'h1;
    if (instr_tick && t1_run) begin
      next_st.t1_pre = st.t1_pre + 3'h1;
    end
    if (t1_tick) begin
      t1_sum = {1'b0, st.t1_cnt} + 17'h00001;
      next_st.t1_cnt = t1_sum[15:0];
      if (t1_sum[16]) begin
        set_f[`T1_IRQ_BIT] = 1'b1;
      end
    end

    // Compare
    next_st.match_prev = match_eq;
    if (cmp_hit) begin
      set_f[`UNIT_IRQ_BIT] = 1'b1;
      case (mode)
        `MODE_SET: next_st.out_latch = 1'b1;
        `MODE_CLR: next_st.out_latch = 1'b0;
        `MODE_SPECIAL: begin
          next_st.t1_cnt = 16'h0000;
          next_st.adc_pulse = adc_enabled;
        end
        default: next_st.out_latch = st.out_latch;
      endcase
    end

    // Timer2, prescaler and postscaler
    if (instr_tick && t2_run) begin
      next_st.t2_pre = st.t2_pre + 4'h1;
    end
    if (t2_due) begin
      next_st.t2_cnt = period_end ? 8'h00 : st.t2_cnt + 8'h01;
    end
    if (period_end) begin
      // The postscaler only paces the Timer2 flag
      if (st.t2_post == st.t2_ctl[6:3]) begin
        next_st.t2_post = 4'h0;
        set_f[`T2_IRQ_BIT] = 1'b1;
      end else begin
        next_st.t2_post = st.t2_post + 4'h1;
      end
    end

    // Match on the position the coming edge brings, so the registered pin
    // falls exactly duty steps after it rose at period start
    duty_hit = (pwm_pos(next_st) == {st.match_hi, st.duty_lat});

    // PWM
    if (pwm_mode) begin
      if (period_end) begin
        next_st.match_hi = st.match_lo;
        next_st.duty_lat = st.unit_ctl[5:4];
        next_st.out_latch = ({st.match_lo, st.unit_ctl[5:4]} != 10'h000);
      end else if (duty_hit) begin
        next_st.out_latch = 1'b0;
      end
    end
    if (mode == `MODE_OFF) begin
      next_st.out_latch = 1'b0;
      next_st.duty_lat = 2'h0;
    end

    // Register writes
    if (wr_fire && st.wok && st.wstb) begin
      case (st.widx)
        `IDX_IRQ_FLAGS: clr_f = st.wdata;
        `IDX_T1_LOW: next_st.t1_cnt[7:0] = st.wdata;
        `IDX_T1_HIGH: next_st.t1_cnt[15:8] = st.wdata;
        `IDX_T1_CTL: next_st.t1_ctl = st.wdata & `T1_CTL_MASK;
        `IDX_T2_COUNT: next_st.t2_cnt = st.wdata;
        `IDX_T2_CTL: next_st.t2_ctl = st.wdata & `T2_CTL_MASK;
        `IDX_MATCH_LOW: next_st.match_lo = st.wdata;
        `IDX_MATCH_HIGH: begin
          if (!pwm_mode) begin
            next_st.match_hi = st.wdata;
          end
        end
        `IDX_UNIT_CTL: begin
          next_st.unit_ctl = st.wdata & `UNIT_CTL_MASK;
          if (st.wdata[3:0] == `MODE_OFF) begin
            next_st.out_latch = 1'b0;
          end
        end
        `IDX_IRQ_EN: next_st.enables = st.wdata & `IRQ_MASK;
        `IDX_T2_PERIOD: next_st.period = st.wdata;
        default: next_st.period = next_st.period;
      endcase
    end

    // Sticky flags: a set in the clearing cycle wins
    next_st.flags = ((st.flags & ~clr_f) | set_f) & `IRQ_MASK;
    next_st.irq_q = |(next_st.flags & next_st.enables);
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  off_forces_low_a:
    assert property (wr_fire && st.wok && st.wstb && st.widx == `IDX_UNIT_CTL &&
                     st.wdata[3:0] == 4'h0 |=> !unit_output_pin ##1 !unit_output_pin)
    else $error("output not low after unit control cleared");

  swi_pin_kept_a:
    assert property (mode == `MODE_SWI && cmp_hit && !wr_fire
                     |=> $stable(unit_output_pin) && st.flags[`UNIT_IRQ_BIT])
    else $error("software interrupt compare touched pin or missed flag");

  special_event_a:
    assert property (mode == `MODE_SPECIAL && cmp_hit && !wr_fire
                     |=> st.t1_cnt == 16'h0000 && adc_start == $past(adc_enabled))
    else $error("special event did not clear timer1 or start conversion");

  timer2_step_a:
    assert property (t2_due && !period_end && !wr_fire
                     |=> st.t2_cnt == $past(st.t2_cnt) + 8'h01)
    else $error("timer2 did not step by one");

  period_wrap_a:
    assert property (pwm_mode && period_end && !wr_fire
                     |=> st.t2_cnt == 8'h00 && st.match_hi == $past(st.match_lo) &&
                         st.duty_lat == $past(st.unit_ctl[5:4]))
    else $error("period end did not clear timer2 or load duty");

  postscale_free_a:
    assert property (t2_due && st.t2_cnt == st.period && st.t2_post != st.t2_ctl[6:3]
                     && !wr_fire |=> st.t2_cnt == 8'h00)
    else $error("postscaler changed the period");

  duty_clear_a:
    assert property (pwm_mode && !period_end && duty_hit && !wr_fire
                     |=> !unit_output_pin)
    else $error("pin not cleared at duty match");

  over_period_high_a:
    assert property (pwm_mode && unit_output_pin && !period_end && !wr_fire &&
                     {st.match_hi, st.duty_lat} > {st.period, 2'h3}
                     |=> unit_output_pin)
    else $error("pin cleared although duty exceeds period");

  zero_duty_low_a:
    assert property (pwm_mode && period_end && !wr_fire &&
                     {st.match_lo, st.unit_ctl[5:4]} == 10'h000
                     |=> !unit_output_pin)
    else $error("pin set with zero duty");

  prescale_four_a:
    assert property (t2_due && st.t2_ctl[1:0] == 2'b01 |-> st.t2_pre[1:0] == 2'h3)
    else $error("divide by four prescale stepped early");

  high_read_only_a:
    assert property (pwm_mode && !period_end |=> $stable(st.match_hi))
    else $error("high duty buffer changed outside period end");

  set_on_match_a:
    assert property (mode == `MODE_SET && cmp_hit && !wr_fire |=> unit_output_pin)
    else $error("set-on-match mode did not drive pin high");

  cmp_flag_a:
    assert property (cmp_hit |=> st.flags[`UNIT_IRQ_BIT])
    else $error("compare match did not set flag");

endmodule

// >>> tb/pin_load.sv
/*
  Load on the unit output pin: measures the last high width and the
  rise-to-rise period in clk_sys cycles. Assumes the pin drives it alone.
*/
`timescale 1ns/100ps

module pin_load (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic pin,
  output int high_len,
  output int period_len
);
  int hc;
  int pc;
  logic pin_q;
  // The pin is an output for the whole run; no port latch in between
  always_ff @(posedge clk_sys) begin
    pin_q <= pin;
    pc <= pc + 1;
    hc <= pin ? hc + 1 : 0;
    if (!rst_n) begin
      pc <= 0;
      hc <= 0;
      high_len <= 0;
      period_len <= 0;
    end else begin
      if (pin && !pin_q) begin
        period_len <= pc;
        pc <= 1;
      end
      if (!pin && pin_q) begin
        high_len <= hc;
      end
    end
  end
endmodule

// >>> tb/tb.sv
/*
  Self-checking bench of the compare and PWM unit over AXI4-Lite.
  Assumes the register header and package of the design.
*/
`timescale 1ns/100ps
`include "cmp_pwm_regs.svh"

module tb;
  logic clk_sys, rst_n, awvalid, wvalid, bready, arvalid, rready, adc_enabled;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, adc_start, pin, irq;
  int fail_count, num_checks, adc_count, high_len, period_len;

  compare_and_pwm_unit uut (.clk_sys(clk_sys), .rst_n(rst_n), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .adc_enabled(adc_enabled), .adc_start(adc_start),
    .unit_output_pin(pin), .irq(irq));
  pin_load load (.clk_sys(clk_sys), .rst_n(rst_n), .pin(pin), .high_len(high_len),
    .period_len(period_len));

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      adc_count <= 0;
    end else if (adc_start === 1'b1) begin
      adc_count <= adc_count + 1;
    end
  end

  task automatic stop_test();
    if (fail_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // ---------------------------------------------------------------
  // Bus cycles
  // ---------------------------------------------------------------
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, output logic [1:0] resp);
    logic a, w, b;
    @(posedge clk_sys);
    awaddr <= {2'b00, idx, 2'b00};
    wdata <= {24'h000000, d};
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    resp = 2'bxx;
    for (int n = 0; n < 100; n++) begin
      @(negedge clk_sys);
      a = awvalid && awready;
      w = wvalid && wready;
      b = bready && bvalid;
      if (b) resp = bresp;
      @(posedge clk_sys);
      if (a) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) begin
        bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic w8(input logic [7:0] idx, input logic [7:0] d);
    logic [1:0] r;
    wr(idx, d, r);
    chk("bresp", 2'b00, r);
  endtask

  task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] resp);
    logic a, r;
    @(posedge clk_sys);
    araddr <= {2'b00, idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    d = 'x;
    resp = 2'bxx;
    for (int n = 0; n < 100; n++) begin
      @(negedge clk_sys);
      a = arvalid && arready;
      r = rready && rvalid;
      if (r) d = rdata;
      if (r) resp = rresp;
      @(posedge clk_sys);
      if (a) arvalid <= 1'b0;
      if (r) begin
        rready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic rchk(input string nm, input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(idx, d, r);
    chk(nm, exp, d);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset_values();
    logic [7:0] ri [7] = '{`IDX_IRQ_FLAGS, `IDX_T1_CTL, `IDX_T2_COUNT, `IDX_T2_CTL,
      `IDX_UNIT_CTL, `IDX_IRQ_EN, `IDX_T2_PERIOD};
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 7; i++) rchk("reset_value", ri[i], (i == 6) ? 32'h000000FF : 32'h0);
    rd(8'h20, d, r);
    chk("unmapped_rresp", 2'b10, r);
    wr(8'h21, 8'h5A, r);
    chk("unmapped_bresp", 2'b10, r);
  endtask

  task automatic cmp_case(input logic [3:0] mode, input logic en, input logic exp_pin,
                          input int exp_adc);
    logic [31:0] d;
    logic [1:0] r;
    int a0;
    w8(`IDX_T1_CTL, 8'h00);
    w8(`IDX_T1_LOW, 8'h00);
    w8(`IDX_T1_HIGH, 8'h00);
    w8(`IDX_IRQ_FLAGS, 8'h07);
    adc_enabled <= en;
    w8(`IDX_UNIT_CTL, {4'h0, mode});
    a0 = adc_count;
    w8(`IDX_T1_CTL, 8'h01); // Internal synchronous clock only
    d = 0;
    for (int n = 0; n < 150 && d[2] !== 1'b1; n++) rd(`IDX_IRQ_FLAGS, d, r);
    chk("match_flag", 1'b1, d[2]);
    chk("irq_level", 1'b1, irq);
    chk("pin_after_match", exp_pin, pin);
    chk("adc_starts", exp_adc, adc_count - a0);
    rd(`IDX_T1_LOW, d, r);
    if (mode == `MODE_SPECIAL) chk("timer1_cleared", 1'b1, d < 8);
  endtask

  task automatic t_compare();
    logic [31:0] d;
    logic [1:0] r;
    w8(`IDX_MATCH_LOW, 8'h40);
    w8(`IDX_MATCH_HIGH, 8'h00);
    w8(`IDX_IRQ_EN, 8'h04);
    cmp_case(`MODE_SET, 1'b1, 1'b1, 0);
    cmp_case(`MODE_SWI, 1'b1, 1'b1, 0);
    cmp_case(`MODE_SPECIAL, 1'b1, 1'b1, 1);
    cmp_case(`MODE_SPECIAL, 1'b0, 1'b1, 0);
    cmp_case(`MODE_CLR, 1'b1, 1'b0, 0);
    cmp_case(`MODE_SET, 1'b1, 1'b1, 0);
    w8(`IDX_UNIT_CTL, `RST_ZERO);
    chk("pin_after_off", 1'b0, pin);
    w8(`IDX_IRQ_EN, 8'h00);
    chk("irq_masked", 1'b0, irq);
    w8(`IDX_IRQ_FLAGS, 8'h04);
    rd(`IDX_IRQ_FLAGS, d, r);
    chk("flag_cleared", 1'b0, d[2]);
  endtask

  task automatic pwm_case(input logic [1:0] pre, input logic [3:0] post, input logic [7:0] per,
                          input logic [9:0] duty, input int exp_high, input int exp_per);
    int hi;
    w8(`IDX_UNIT_CTL, `RST_ZERO);
    w8(`IDX_T2_CTL, 8'h00);
    w8(`IDX_T2_COUNT, 8'h00);
    // Period, duty, timer, then mode
    w8(`IDX_T2_PERIOD, per);
    w8(`IDX_MATCH_LOW, duty[9:2]);
    w8(`IDX_UNIT_CTL, {2'b00, duty[1:0], 4'h0});
    w8(`IDX_T2_CTL, {1'b0, post, 1'b1, pre});
    w8(`IDX_UNIT_CTL, {2'b00, duty[1:0], 4'hC});
    repeat (3 * exp_per) @(posedge clk_sys);
    hi = 0;
    for (int n = 0; n < exp_per; n++) begin
      @(negedge clk_sys);
      if (pin === 1'b1) hi++;
    end
    chk("pwm_high_cycles", exp_high, hi);
    if (exp_high > 0 && exp_high < exp_per) begin
      chk("pwm_period", exp_per, period_len);
      chk("load_high", exp_high, high_len);
    end
    rchk("duty_buffer", `IDX_MATCH_HIGH, {24'h0, duty[9:2]});
    w8(`IDX_MATCH_HIGH, 8'h55);
    rchk("duty_buffer_ro", `IDX_MATCH_HIGH, {24'h0, duty[9:2]});
  endtask

  task automatic t_pwm();
    pwm_case(2'b00, 4'h0, 8'h03, 10'd6, 6, 16);
    pwm_case(2'b01, 4'h3, 8'h03, 10'd10, 40, 64);
    pwm_case(2'b10, 4'h0, 8'h01, 10'd5, 80, 128);
    pwm_case(2'b00, 4'h0, 8'h03, 10'd20, 16, 16);
    pwm_case(2'b00, 4'h0, 8'h03, 10'd0, 0, 16);
  endtask

  initial begin
    rst_n = 1'b0;
    awaddr = '0;
    awvalid = 1'b0;
    wdata = '0;
    wstrb = 4'h0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = '0;
    arvalid = 1'b0;
    rready = 1'b0;
    adc_enabled = 1'b0;
    fail_count = 0;
    num_checks = 0;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset_values();
    t_compare();
    t_pwm();
    stop_test();
  end

  initial begin
    #240000;
    fail_count++;
    stop_test();
  end
endmodule
